// *** ep_model.sv ***
// Endpoint model answering config requests with a completion.
// Assumes one outstanding request; delay, status and drop set by the bench.
`timescale 1ns/1ps
module ep_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic issue,
	input wire logic [7:0] delay,
	input wire logic [2:0] status,
	input wire logic drop,
	output logic cpl_valid,
	output logic [2:0] cpl_status
);
	logic [7:0] cnt;
	logic pend;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 1'b0;
			cnt <= '0;
			cpl_valid <= 1'b0;
			cpl_status <= 3'h7;
		end else begin
			cpl_valid <= 1'b0;
			// Status line carries noise outside a completion
			cpl_status <= ~cpl_status;
			if (issue && !drop) begin
				pend <= 1'b1;
				cnt <= delay;
			end else if (pend && cnt == 8'h0) begin
				pend <= 1'b0;
				cpl_valid <= 1'b1;
				cpl_status <= status;
			end else if (pend) begin
				cnt <= cnt - 8'h1;
			end
		end
	end
endmodule

// *** rp_irq_pkg.sv ***
// Constants shared by the root port interrupt receiver.
// Assumes a 32-bit Avalon-MM register bus and 50 MHz system clock.
package rp_irq_pkg;
	// Register byte offsets
	localparam logic [5:0] OFS_DECODE = 6'h00;
	localparam logic [5:0] OFS_MASK = 6'h04;
	localparam logic [5:0] OFS_STATUS = 6'h08;
	localparam logic [5:0] OFS_FIFO1 = 6'h0c;
	localparam logic [5:0] OFS_FIFO2 = 6'h10;
	localparam logic [5:0] OFS_INTX_DEC = 6'h14;
	localparam logic [5:0] OFS_INTX_MASK = 6'h18;
	localparam logic [5:0] OFS_MSI_DEC_LO = 6'h1c;
	localparam logic [5:0] OFS_MSI_DEC_HI = 6'h20;
	localparam logic [5:0] OFS_MSI_MASK_LO = 6'h24;
	localparam logic [5:0] OFS_MSI_MASK_HI = 6'h28;
	localparam logic [5:0] OFS_MSI_BASE_LO = 6'h2c;
	localparam logic [5:0] OFS_MSI_BASE_HI = 6'h30;
	localparam logic [5:0] OFS_BUS_NUMS = 6'h34;
	localparam logic [5:0] OFS_XLATE = 6'h38;
	// Field positions, FIFO depth and MSI window width
	localparam int BIT_INTX = 16;
	localparam int BIT_MSI = 17;
	localparam int BIT_NOT_EMPTY = 18;
	localparam int BIT_OVERFLOW = 19;
	localparam int BIT_POP = 31;
	localparam int BIT_FIFO_VALID = 30;
	localparam int BIT_FIFO_ASSERT = 16;
	localparam int BIT_FIFO_IS_MSI = 29;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW = 4;
	localparam int MSI_WIN_BITS = 12;
	// Reset values
	localparam logic [31:0] RST_MASK = 32'h0000_0000;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	// Completion timeout
	localparam int CLK_HZ = 50_000_000;
	localparam int CPL_TIMEOUT_US = 50;
	localparam int CPL_TIMEOUT_CYC = CPL_TIMEOUT_US * (CLK_HZ / 1_000_000);
	// Config response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Completion status and config state encoding
	localparam logic [2:0] CPL_SC = 3'h0;
	localparam logic [2:0] CPL_UR = 3'h1;
	typedef enum logic [2:0] {
		CFG_IDLE = 3'b001,
		CFG_WAIT = 3'b010,
		CFG_DONE = 3'b100
	} cfg_state_t;
endpackage

// *** rp_irq_rx.sv ***
// Root port interrupt receiver: FIFO or decode scheme, MSI window, cfg error answers.
// Assumes link-side strobes are synchronous to CLK_SYS, one cycle each.
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Contract
// [RL1] Config access to bus outside primary..subordinate answers SLVERR.
// [RL2] Config access to valid bus timing out answers SLVERR.
// [RL3] Config write below subordinate with UR completion answers SLVERR.
// [RL4] Two build-time schemes, queued FIFO default, direct decode optional.
// [RL5] FIFO scheme: INTx sets decode bit 16; output when mask 16 set.
// [RL6] Status bit 18 shows FIFO not empty, bit 19 overflow.
// [RL7] FIFO register one shows head line and assert or deassert.
// [RL8] Writing one to FIFO register one bit 31 pops the head.
// [RL9] Write one to decode bits 16 and 17 clears INTx, MSI pending.
// [RL10] Memory writes in 4 KB window above MSI base become MSI, not forwarded.
// [RL11] FIFO scheme: MSI sets decode bit 17; output when mask 17 set.
// [RL12] FIFO register two shows queued MSI message data.
// [RL13] Software polls all unserviced sources after overflow.
// [RL14] Clearing mask bit drops output; setting it re-enables.
// [RL15] MSI-X writes forwarded undecoded; endpoints place them outside window.
// [RL16] Forwarded writes pass through PCIe-to-AXI address translation.
// [RL17] Decode scheme: INTx assert sets line bit; output when masked on.
// [RL18] Decode scheme: INTx deassert clears that line bit automatically.
// [RL19] Decode scheme: MSI data bits 5:0 are the vector number.
// [RL20] Decode scheme: vector bits set; low and high outputs when unmasked.
// [RL21] Write one to MSI vector status bit clears it.
// [RL22] Software drains FIFO before clearing decode status bit.
// [RL23] Message on full FIFO dropped; sticky overflow until reset or clear.
module rp_irq_rx #(
	parameter bit DECODE_SCHEME = 1'b0
) (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic INTX_VALID,
	input wire logic [1:0] INTX_LINE,
	input wire logic INTX_ASSERT,
	input wire logic MWR_VALID,
	input wire logic [63:0] MWR_ADDR,
	input wire logic [31:0] MWR_DATA,
	output logic FWD_VALID,
	output logic [63:0] FWD_ADDR,
	output logic [31:0] FWD_DATA,
	input wire logic CFG_REQ,
	input wire logic CFG_WRITE,
	input wire logic [7:0] CFG_BUS,
	output logic CFG_ISSUE,
	input wire logic CPL_VALID,
	input wire logic [2:0] CPL_STATUS,
	output logic CFG_RESP_VALID,
	output logic [1:0] CFG_RESP,
	output logic INTERRUPT_OUT,
	output logic MSI_VECTOR_IRQ_LOW,
	output logic MSI_VECTOR_IRQ_HIGH
);
	logic rst_meta, rst_n;
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Registers
	logic [31:0] decode, mask, intx_mask, msi_mask_lo, msi_mask_hi;
	logic [31:0] msi_base_lo, msi_base_hi, bus_nums, xlate;
	logic [3:0] intx_dec;
	logic [63:0] msi_dec;
	logic overflow;
	localparam int FIFO_DEPTH = rp_irq_pkg::FIFO_DEPTH;
	logic [31:0] fifo_mem [FIFO_DEPTH];
	logic [rp_irq_pkg::FIFO_AW:0] wr_ptr, rd_ptr;

	// Bus access: one wait cycle per request
	logic ack;
	wire req = (AVS_READ | AVS_WRITE) & ~ack;
	wire wr_go = AVS_WRITE & ack;
	wire [31:0] wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
	wire [31:0] wbits = AVS_WRITEDATA & wmask;
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction
	wire wr_decode = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_DECODE);
	wire wr_mask = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_MASK);
	wire wr_status = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_STATUS);
	wire wr_fifo1 = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_FIFO1);
	wire wr_intx_mask = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_INTX_MASK);
	wire wr_msi_dec_lo = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_MSI_DEC_LO);
	wire wr_msi_dec_hi = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_MSI_DEC_HI);
	wire wr_msi_mask_lo = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_MSI_MASK_LO);
	wire wr_msi_mask_hi = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_MSI_MASK_HI);
	wire wr_base_lo = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_MSI_BASE_LO);
	wire wr_base_hi = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_MSI_BASE_HI);
	wire wr_bus = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_BUS_NUMS);
	wire wr_xlate = wr_go & (AVS_ADDRESS == rp_irq_pkg::OFS_XLATE);

	// Link side classification
	wire [63:0] msi_base = {msi_base_hi, msi_base_lo[31:12], 12'h000};
	// [RL10] MSI window hit
	wire msi_hit = MWR_VALID &
		(MWR_ADDR[63:rp_irq_pkg::MSI_WIN_BITS] == msi_base[63:rp_irq_pkg::MSI_WIN_BITS]);
	// [RL15] Non-window writes, MSI-X included, go out
	wire fwd_take = MWR_VALID & ~msi_hit;

	// FIFO scheme queue
	wire fifo_empty = (wr_ptr == rd_ptr);
	wire fifo_full = (wr_ptr[rp_irq_pkg::FIFO_AW-1:0] == rd_ptr[rp_irq_pkg::FIFO_AW-1:0]) &
		(wr_ptr[rp_irq_pkg::FIFO_AW] != rd_ptr[rp_irq_pkg::FIFO_AW]);
	wire msg_in = !DECODE_SCHEME & (INTX_VALID | msi_hit);
	// [RL8] Pop on write one to bit 31
	wire pop = wr_fifo1 & wbits[rp_irq_pkg::BIT_POP] & ~fifo_empty;
	wire push = msg_in & (~fifo_full | pop);
	// [RL23] Drop on full
	wire drop = msg_in & fifo_full & ~pop;
	wire [31:0] entry = INTX_VALID ?
		{15'h0000, INTX_ASSERT, 14'h0000, INTX_LINE} :
		{2'h0, 1'b1, 29'h0000_0000};
	logic [31:0] msi_data_q [FIFO_DEPTH];
	wire [31:0] head = fifo_mem[rd_ptr[rp_irq_pkg::FIFO_AW-1:0]];
	wire [31:0] head_data = msi_data_q[rd_ptr[rp_irq_pkg::FIFO_AW-1:0]];

	always_ff @(posedge CLK_SYS) begin
		if (push) begin
			fifo_mem[wr_ptr[rp_irq_pkg::FIFO_AW-1:0]] <= entry;
			msi_data_q[wr_ptr[rp_irq_pkg::FIFO_AW-1:0]] <= INTX_VALID ? 32'h0000_0000 : MWR_DATA;
		end
	end

	// Decode scheme events
	// [RL19] Vector from data 5:0
	wire [5:0] vec = MWR_DATA[5:0];
	wire [63:0] vec_set = (DECODE_SCHEME & msi_hit & ~INTX_VALID) ? (64'h1 << vec) : 64'h0;
	wire [3:0] line_hot = 4'h1 << INTX_LINE;
	wire intx_dec_ev = DECODE_SCHEME & INTX_VALID;
	wire [63:0] msi_clr = {wr_msi_dec_hi ? wbits : 32'h0, wr_msi_dec_lo ? wbits : 32'h0};

	// FIFO scheme decode bits; set beats clear
	wire set_intx = !DECODE_SCHEME & INTX_VALID;
	wire set_msi = !DECODE_SCHEME & msi_hit;
	logic [31:0] next_decode;
	always_comb begin
		next_decode = decode;
		// [RL9] Write one clears
		if (wr_decode) begin
			next_decode = decode & ~wbits;
		end
		// [RL5] INTx status
		if (set_intx) begin
			next_decode[rp_irq_pkg::BIT_INTX] = 1'b1;
		end
		// [RL11] MSI status
		if (set_msi) begin
			next_decode[rp_irq_pkg::BIT_MSI] = 1'b1;
		end
		next_decode = next_decode & 32'h0003_0000;
	end

	logic [3:0] next_intx_dec;
	always_comb begin
		next_intx_dec = intx_dec;
		if (intx_dec_ev) begin
			// [RL17] Set on assert
			if (INTX_ASSERT) begin
				next_intx_dec = intx_dec | line_hot;
			// [RL18] Auto clear on deassert
			end else begin
				next_intx_dec = intx_dec & ~line_hot;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			decode <= rp_irq_pkg::RST_ZERO;
			intx_dec <= 4'h0;
			msi_dec <= 64'h0;
			overflow <= 1'b0;
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			ack <= req;
			decode <= next_decode;
			intx_dec <= next_intx_dec;
			// [RL21] Vector write-one clear, set wins
			msi_dec <= (msi_dec & ~msi_clr) | vec_set;
			// [RL23] Sticky overflow, write one clears, set wins
			overflow <= drop | (overflow & ~(wr_status & wbits[rp_irq_pkg::BIT_OVERFLOW]));
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop) rd_ptr <= rd_ptr + 1'b1;
		end
	end

	// FIFO scheme enables
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			mask <= rp_irq_pkg::RST_MASK;
		end else if (wr_mask) begin
			mask <= merge(mask, AVS_WRITEDATA, wmask);
		end
	end

	// Per-line enables
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			intx_mask <= rp_irq_pkg::RST_MASK;
		end else if (wr_intx_mask) begin
			intx_mask <= merge(intx_mask, AVS_WRITEDATA, wmask);
		end
	end

	// Vector enables 0 to 31
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			msi_mask_lo <= rp_irq_pkg::RST_MASK;
		end else if (wr_msi_mask_lo) begin
			msi_mask_lo <= merge(msi_mask_lo, AVS_WRITEDATA, wmask);
		end
	end

	// Vector enables 32 to 63
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			msi_mask_hi <= rp_irq_pkg::RST_MASK;
		end else if (wr_msi_mask_hi) begin
			msi_mask_hi <= merge(msi_mask_hi, AVS_WRITEDATA, wmask);
		end
	end

	// Window base, low word
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			msi_base_lo <= rp_irq_pkg::RST_ZERO;
		end else if (wr_base_lo) begin
			msi_base_lo <= merge(msi_base_lo, AVS_WRITEDATA, wmask);
		end
	end

	// Window base, high word
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			msi_base_hi <= rp_irq_pkg::RST_ZERO;
		end else if (wr_base_hi) begin
			msi_base_hi <= merge(msi_base_hi, AVS_WRITEDATA, wmask);
		end
	end

	// Primary, secondary, subordinate
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			bus_nums <= rp_irq_pkg::RST_ZERO;
		end else if (wr_bus) begin
			bus_nums <= merge(bus_nums, AVS_WRITEDATA, wmask);
		end
	end

	// Upper address offset
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			xlate <= rp_irq_pkg::RST_ZERO;
		end else if (wr_xlate) begin
			xlate <= merge(xlate, AVS_WRITEDATA, wmask);
		end
	end

	// Read mux
	logic [31:0] rd_mux;
	always_comb begin
		case (AVS_ADDRESS)
			rp_irq_pkg::OFS_DECODE: rd_mux = decode;
			rp_irq_pkg::OFS_MASK: rd_mux = mask;
			// [RL6] Not empty and overflow
			rp_irq_pkg::OFS_STATUS: rd_mux = {12'h000, overflow, ~fifo_empty, 18'h00000};
			// [RL7] Head line and assert flag
			rp_irq_pkg::OFS_FIFO1: rd_mux = fifo_empty ? 32'h0 : (head | 32'h4000_0000);
			// [RL12] Head MSI data
			rp_irq_pkg::OFS_FIFO2: rd_mux = fifo_empty ? 32'h0 : head_data;
			rp_irq_pkg::OFS_INTX_DEC: rd_mux = {28'h0000000, intx_dec};
			rp_irq_pkg::OFS_INTX_MASK: rd_mux = intx_mask;
			rp_irq_pkg::OFS_MSI_DEC_LO: rd_mux = msi_dec[31:0];
			rp_irq_pkg::OFS_MSI_DEC_HI: rd_mux = msi_dec[63:32];
			rp_irq_pkg::OFS_MSI_MASK_LO: rd_mux = msi_mask_lo;
			rp_irq_pkg::OFS_MSI_MASK_HI: rd_mux = msi_mask_hi;
			rp_irq_pkg::OFS_MSI_BASE_LO: rd_mux = msi_base_lo;
			rp_irq_pkg::OFS_MSI_BASE_HI: rd_mux = msi_base_hi;
			rp_irq_pkg::OFS_BUS_NUMS: rd_mux = bus_nums;
			rp_irq_pkg::OFS_XLATE: rd_mux = xlate;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Configuration access checks
	wire [7:0] bus_pri = bus_nums[7:0];
	wire [7:0] bus_sec = bus_nums[15:8];
	wire [7:0] bus_sub = bus_nums[23:16];
	logic [31:0] cfg_cnt;
	logic cfg_wr_q;
	rp_irq_pkg::cfg_state_t cfg_state, next_cfg_state;
	// [RL1] Out of range
	wire bus_bad = (CFG_BUS < bus_pri) | (CFG_BUS > bus_sub);
	wire cfg_start = (cfg_state == rp_irq_pkg::CFG_IDLE) & CFG_REQ;
	// [RL2] Timeout
	wire cfg_tmo = (cfg_state == rp_irq_pkg::CFG_WAIT) &
		(cfg_cnt == rp_irq_pkg::CPL_TIMEOUT_CYC - 1);
	wire cpl_in = (cfg_state == rp_irq_pkg::CFG_WAIT) & CPL_VALID;
	// [RL3] UR on write
	wire cpl_bad = cfg_wr_q & (CPL_STATUS == rp_irq_pkg::CPL_UR);
	always_comb begin
		case (cfg_state)
			rp_irq_pkg::CFG_IDLE: next_cfg_state = !cfg_start ? rp_irq_pkg::CFG_IDLE :
				(bus_bad ? rp_irq_pkg::CFG_DONE : rp_irq_pkg::CFG_WAIT);
			rp_irq_pkg::CFG_WAIT: next_cfg_state = (cpl_in | cfg_tmo) ?
				rp_irq_pkg::CFG_DONE : rp_irq_pkg::CFG_WAIT;
			rp_irq_pkg::CFG_DONE: next_cfg_state = rp_irq_pkg::CFG_IDLE;
			default: next_cfg_state = rp_irq_pkg::CFG_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			cfg_state <= rp_irq_pkg::CFG_IDLE;
			cfg_cnt <= 32'h0;
			cfg_wr_q <= 1'b0;
			CFG_ISSUE <= 1'b0;
			CFG_RESP_VALID <= 1'b0;
			CFG_RESP <= rp_irq_pkg::RESP_OKAY;
		end else begin
			cfg_state <= next_cfg_state;
			cfg_cnt <= (cfg_state == rp_irq_pkg::CFG_WAIT) ? cfg_cnt + 32'h1 : 32'h0;
			if (cfg_start) cfg_wr_q <= CFG_WRITE;
			CFG_ISSUE <= cfg_start & ~bus_bad & (CFG_BUS != bus_pri);
			CFG_RESP_VALID <= (cfg_start & bus_bad) | cpl_in | cfg_tmo;
			if (cfg_start & bus_bad) CFG_RESP <= rp_irq_pkg::RESP_SLVERR;
			else if (cfg_tmo) CFG_RESP <= rp_irq_pkg::RESP_SLVERR;
			else if (cpl_in) CFG_RESP <= cpl_bad ? rp_irq_pkg::RESP_SLVERR : rp_irq_pkg::RESP_OKAY;
		end
	end

	// [RL4] Scheme select; [RL14] mask gating
	wire next_irq = DECODE_SCHEME ? |(intx_dec & intx_mask[3:0]) :
		|(decode[17:16] & mask[17:16]);
	// [RL20] Vector outputs
	wire next_vec_low = DECODE_SCHEME & |(msi_dec[31:0] & msi_mask_lo);
	wire next_vec_high = DECODE_SCHEME & |(msi_dec[63:32] & msi_mask_hi);

	// Outputs from flops
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			AVS_READDATA <= 32'h0;
			AVS_WAITREQUEST <= 1'b1;
			FWD_VALID <= 1'b0;
			FWD_ADDR <= 64'h0;
			FWD_DATA <= 32'h0;
			INTERRUPT_OUT <= 1'b0;
			MSI_VECTOR_IRQ_LOW <= 1'b0;
			MSI_VECTOR_IRQ_HIGH <= 1'b0;
		end else begin
			AVS_WAITREQUEST <= ~req;
			AVS_READDATA <= rd_mux;
			FWD_VALID <= fwd_take;
			// [RL16] Translation offset applied
			FWD_ADDR <= MWR_ADDR + {xlate, 32'h0};
			FWD_DATA <= MWR_DATA;
			INTERRUPT_OUT <= next_irq;
			MSI_VECTOR_IRQ_LOW <= next_vec_low;
			MSI_VECTOR_IRQ_HIGH <= next_vec_high;
		end
	end
endmodule

// *** rp_irq_rx_chk.sv ***
// Concurrent checks for the root port interrupt receiver, FIFO scheme.
// Assumes whole-word register writes; sees only the top-level ports.
`timescale 1ns/1ps
module rp_irq_rx_chk (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic INTX_VALID,
	input wire logic MWR_VALID,
	input wire logic [63:0] MWR_ADDR,
	input wire logic FWD_VALID,
	input wire logic [63:0] FWD_ADDR,
	input wire logic CFG_REQ,
	input wire logic CFG_WRITE,
	input wire logic [7:0] CFG_BUS,
	input wire logic CPL_VALID,
	input wire logic [2:0] CPL_STATUS,
	input wire logic CFG_RESP_VALID,
	input wire logic [1:0] CFG_RESP,
	input wire logic INTERRUPT_OUT
);
	logic [31:0] mask, xl, bus;
	logic [51:0] base;
	logic busy, cpl_seen, is_wr;
	logic [1:0] off_cnt;
	wire wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
	wire in_win = MWR_ADDR[63:12] == base;
	wire bad_bus = CFG_BUS < bus[7:0] || CFG_BUS > bus[23:16];
	wire take = CFG_REQ && !busy;
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			mask <= '0;
			xl <= '0;
			bus <= '0;
			base <= '0;
			busy <= 1'b0;
			cpl_seen <= 1'b0;
			is_wr <= 1'b0;
			off_cnt <= '0;
		end else begin
			if (wr_ok && AVS_ADDRESS == rp_irq_pkg::OFS_MASK) mask <= AVS_WRITEDATA;
			if (wr_ok && AVS_ADDRESS == rp_irq_pkg::OFS_XLATE) xl <= AVS_WRITEDATA;
			if (wr_ok && AVS_ADDRESS == rp_irq_pkg::OFS_BUS_NUMS) bus <= AVS_WRITEDATA;
			if (wr_ok && AVS_ADDRESS == rp_irq_pkg::OFS_MSI_BASE_LO) base[19:0] <= AVS_WRITEDATA[31:12];
			if (wr_ok && AVS_ADDRESS == rp_irq_pkg::OFS_MSI_BASE_HI) base[51:20] <= AVS_WRITEDATA;
			if (take) busy <= 1'b1;
			else if (CFG_RESP_VALID) busy <= 1'b0;
			if (take) cpl_seen <= 1'b0;
			else if (CPL_VALID && busy) cpl_seen <= 1'b1;
			if (take) is_wr <= CFG_WRITE;
			if (mask[17:16] != 2'h0) off_cnt <= '0;
			else if (off_cnt != 2'h3) off_cnt <= off_cnt + 2'h1;
		end
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	sequence intx_hit;
		INTX_VALID && mask[16];
	endsequence
	sequence msi_hit;
		MWR_VALID && in_win;
	endsequence
	AST_INTX_IRQ: assert property (intx_hit |-> ##2 INTERRUPT_OUT)
		else $error("INTx with mask set gave no interrupt");
	AST_MSI_IRQ: assert property (msi_hit ##0 mask[17] |-> ##2 INTERRUPT_OUT)
		else $error("MSI with mask set gave no interrupt");
	AST_MASK_OFF: assert property (off_cnt == 2'h3 |-> !INTERRUPT_OUT)
		else $error("Interrupt output high with both masks clear");
	AST_MSI_NOFWD: assert property (msi_hit |=> !FWD_VALID)
		else $error("Write in MSI window was forwarded");
	AST_FWD: assert property (MWR_VALID && !in_win |=> FWD_VALID)
		else $error("Write outside MSI window not forwarded");
	AST_XLATE: assert property (FWD_VALID |-> FWD_ADDR == $past(MWR_ADDR) + {xl, 32'h0})
		else $error("Forwarded address not translated");
	AST_BAD_BUS: assert property (take && bad_bus |=> CFG_RESP_VALID && CFG_RESP == 2'h2)
		else $error("Out of range bus not answered with error");
	AST_TIMEOUT: assert property (CFG_RESP_VALID && !cpl_seen |-> CFG_RESP == 2'h2)
		else $error("Config answer without completion not an error");
	AST_UR_WR: assert property (CPL_VALID && busy && is_wr && CPL_STATUS == 3'h1
		|=> CFG_RESP_VALID && CFG_RESP == 2'h2)
		else $error("Write with unsupported completion not an error");
endmodule
bind rp_irq_rx rp_irq_rx_chk chk_u (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .INTX_VALID(INTX_VALID), .MWR_VALID(MWR_VALID),
	.MWR_ADDR(MWR_ADDR), .FWD_VALID(FWD_VALID), .FWD_ADDR(FWD_ADDR), .CFG_REQ(CFG_REQ),
	.CFG_WRITE(CFG_WRITE), .CFG_BUS(CFG_BUS), .CPL_VALID(CPL_VALID), .CPL_STATUS(CPL_STATUS),
	.CFG_RESP_VALID(CFG_RESP_VALID), .CFG_RESP(CFG_RESP), .INTERRUPT_OUT(INTERRUPT_OUT));

// *** rp_irq_rx_tb.sv ***
// Self-checking bench for the receiver in its default FIFO scheme.
// Assumes rp_irq_pkg, the checker and ep_model are compiled first.
`timescale 1ns/1ps
module rp_irq_rx_tb;
	logic clk = 0, arst_n = 0, rd = 0, wr = 0, ival = 0, ias = 0, mval = 0;
	logic creq = 0, cwr = 0, cdrop = 0, wreq, issue, cval, rval, irq;
	logic [5:0] adr = 0;
	logic [31:0] wdat = 0, rdat, mdat = 0;
	logic [63:0] madr = 0;
	logic [1:0] iln = 0, resp;
	logic [7:0] cbus = 0, cdly = 0;
	logic [2:0] cst = 0, cpst;
	logic [31:0] rd_q[$], d;
	logic [1:0] cfg_q[$];
	int err_count = 0, checked = 0, cyc = 0, seed = 32'h558953a8;
	rp_irq_rx dut_u (.CLK_SYS(clk), .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .INTX_VALID(ival), .INTX_LINE(iln), .INTX_ASSERT(ias),
		.MWR_VALID(mval), .MWR_ADDR(madr), .MWR_DATA(mdat), .FWD_VALID(), .FWD_ADDR(),
		.FWD_DATA(), .CFG_REQ(creq), .CFG_WRITE(cwr), .CFG_BUS(cbus), .CFG_ISSUE(issue),
		.CPL_VALID(cval), .CPL_STATUS(cpst), .CFG_RESP_VALID(rval), .CFG_RESP(resp),
		.INTERRUPT_OUT(irq), .MSI_VECTOR_IRQ_LOW(), .MSI_VECTOR_IRQ_HIGH());
	ep_model ep_u (.clk(clk), .rst_n(arst_n), .issue(issue), .delay(cdly), .status(cst),
		.drop(cdrop), .cpl_valid(cval), .cpl_status(cpst));
	always #10 clk = ~clk;
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
		if (rd === 1'b1 && wreq === 1'b0) cmp("readdata", rd_q.pop_front(), rdat);
		if (rval === 1'b1) cmp("cfg_resp", {30'h0, cfg_q.pop_front()}, {30'h0, resp});
	end
	task automatic xfer(input logic [5:0] a, input logic w, input logic [31:0] v);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= v;
		@(posedge clk);
		while (wreq !== 1'b0) @(posedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic avs_rd(input logic [5:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		xfer(a, 1'b0, 32'h0);
	endtask
	task automatic intx(input logic [1:0] l, input logic s);
		ival <= 1'b1;
		iln <= l;
		ias <= s;
		@(posedge clk);
		ival <= 1'b0;
		@(posedge clk);
	endtask
	task automatic mwr(input logic [63:0] a, input logic [31:0] v);
		mval <= 1'b1;
		madr <= a;
		mdat <= v;
		@(posedge clk);
		mval <= 1'b0;
		madr <= ~a;
		mdat <= ~v;
		@(posedge clk);
	endtask
	task automatic cfg(input logic [7:0] b, input logic w, input logic [2:0] st,
		input logic dr, input logic [1:0] e);
		cfg_q.push_back(e);
		creq <= 1'b1;
		cbus <= b;
		cwr <= w;
		cst <= st;
		cdrop <= dr;
		cdly <= 8'($random(seed) & 15);
		@(posedge clk);
		creq <= 1'b0;
		do @(posedge clk); while (rval !== 1'b1);
		@(posedge clk);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		avs_rd(rp_irq_pkg::OFS_MASK, rp_irq_pkg::RST_MASK);
		avs_rd(rp_irq_pkg::OFS_STATUS, 32'h0);
		avs_rd(6'h3c, 32'h0);
		xfer(rp_irq_pkg::OFS_MASK, 1'b1, 32'h0003_0000);
		xfer(rp_irq_pkg::OFS_MSI_BASE_LO, 1'b1, 32'h8000_0000);
		xfer(rp_irq_pkg::OFS_MSI_BASE_HI, 1'b1, 32'h0000_0001);
		xfer(rp_irq_pkg::OFS_XLATE, 1'b1, 32'h0000_0002);
		xfer(rp_irq_pkg::OFS_BUS_NUMS, 1'b1, 32'h0004_0201);
		d = $random(seed);
		intx(d[1:0], 1'b1);
		intx(~d[1:0], 1'b0);
		avs_rd(rp_irq_pkg::OFS_DECODE, 32'h0001_0000);
		avs_rd(rp_irq_pkg::OFS_STATUS, 32'h0004_0000);
		avs_rd(rp_irq_pkg::OFS_FIFO1, {30'h1000_4000, d[1:0]});
		xfer(rp_irq_pkg::OFS_FIFO1, 1'b1, 32'h8000_0000);
		avs_rd(rp_irq_pkg::OFS_FIFO1, {30'h1000_0000, ~d[1:0]});
		xfer(rp_irq_pkg::OFS_FIFO1, 1'b1, 32'h8000_0000);
		avs_rd(rp_irq_pkg::OFS_STATUS, 32'h0);
		xfer(rp_irq_pkg::OFS_MASK, 1'b1, 32'h0);
		repeat (6) @(posedge clk);
		xfer(rp_irq_pkg::OFS_MASK, 1'b1, 32'h0003_0000);
		xfer(rp_irq_pkg::OFS_DECODE, 1'b1, 32'h0001_0000);
		avs_rd(rp_irq_pkg::OFS_DECODE, 32'h0);
		mwr({32'h1, 20'h80000, d[11:0]}, d);
		avs_rd(rp_irq_pkg::OFS_DECODE, 32'h0002_0000);
		avs_rd(rp_irq_pkg::OFS_FIFO2, d);
		xfer(rp_irq_pkg::OFS_FIFO1, 1'b1, 32'h8000_0000);
		// MSI-X just past and below the window
		mwr({32'h1, 32'h8000_1000}, ~d);
		mwr({32'h1, 32'h7fff_fffc}, d);
		xfer(rp_irq_pkg::OFS_DECODE, 1'b1, 32'h0002_0000);
		avs_rd(rp_irq_pkg::OFS_DECODE, 32'h0);
		for (int i = 0; i <= rp_irq_pkg::FIFO_DEPTH; i++) intx(2'(i), 1'b1);
		avs_rd(rp_irq_pkg::OFS_STATUS, 32'h000c_0000);
		for (int i = 0; i < rp_irq_pkg::FIFO_DEPTH; i++) begin
			avs_rd(rp_irq_pkg::OFS_FIFO1, {30'h1000_4000, 2'(i)});
			xfer(rp_irq_pkg::OFS_FIFO1, 1'b1, 32'h8000_0000);
		end
		avs_rd(rp_irq_pkg::OFS_STATUS, 32'h0008_0000);
		xfer(rp_irq_pkg::OFS_STATUS, 1'b1, 32'h0008_0000);
		avs_rd(rp_irq_pkg::OFS_STATUS, 32'h0);
		cfg(8'h09, 1'b0, 3'h0, 1'b0, 2'h2);
		cfg(8'h00, 1'b1, 3'h0, 1'b0, 2'h2);
		cfg(8'h02, 1'b0, 3'h0, 1'b0, 2'h0);
		cfg(8'h04, 1'b1, 3'h1, 1'b0, 2'h2);
		cfg(8'h03, 1'b0, 3'h1, 1'b0, 2'h0);
		cfg(8'h02, 1'b1, 3'h0, 1'b1, 2'h2);
		repeat (2) @(posedge clk);
		wrap_up();
	end
endmodule
